/* File: src/pofp_pkg.sv */
// Shared constants and carriers for the power enable / fault / lock key command block
package pofp_pkg;
    // Command codes
    localparam logic [7:0] CMD_OPERATION  = 8'h01;
    localparam logic [7:0] CMD_ENABLE_CFG = 8'h02;
    localparam logic [7:0] CMD_CLR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_LOCK_KEY   = 8'h0e;
    localparam logic [7:0] CMD_EXT_GUARD  = 8'h0c;
    localparam logic [7:0] CMD_STORE_ALL  = 8'h15;
    localparam logic [7:0] CMD_RESTORE    = 8'h16;
    localparam logic [7:0] CMD_STATUS     = 8'h7e;
    // power_enable_config fields
    localparam int CFG_PU  = 4;
    localparam int CFG_CMD = 3;
    localparam int CFG_CPR = 2;
    localparam int CFG_POL = 1;
    localparam int CFG_CPA = 0;
    // Operation fields and guard field
    localparam int OP_ON       = 7;
    localparam int OP_SOFT     = 6;
    localparam int GUARD_NVM_STORE_LOCK_SELECT = 0;
    // Status bit positions, faults sit above these
    localparam int ST_IVC = 0;
    localparam int ST_IVD = 1;
    // Lock attempt report codes
    localparam logic [7:0] ATT_0   = 8'h10;
    localparam logic [7:0] ATT_1   = 8'h11;
    localparam logic [7:0] ATT_2   = 8'h12;
    localparam logic [7:0] ATT_MAX = 8'h1f;
    localparam logic [1:0] ATT_LIM = 2'h3;
    // Reset values
    localparam logic [7:0] OP_RST    = 8'h04;
    localparam logic [7:0] GUARD_RST = 8'h00;

    typedef enum logic [1:0] {POFP_WR = 2'h0, POFP_RD = 2'h1, POFP_ARA = 2'h3} pofp_kind_t;
    typedef enum logic {LK_IDLE = 1'b0, LK_WAIT = 1'b1} pofp_lk_st_t;

    typedef struct packed {
        pofp_kind_t  kind;
        logic [7:0]  cmd;
        logic [2:0]  nbytes;
        logic [31:0] data;
    } pofp_req_t;

    typedef struct packed {
        logic        nack;
        logic [2:0]  len;
        logic [31:0] data;
    } pofp_rsp_t;
endpackage

/* File: src/pofp_ctl.sv */
// Command handling: enable config, clear faults, alert release and lock key
//
// Function
// - Secondary strap forces gating off, ignores config writes
// - Secondary: config access NACKs, invalid command, alert
// - Config bits 7:5 read zero, bit1 one
// - Gating bit clear: convert whenever input present
// - Gating bit set: pin/command select start/stop
// - Bit 3 selects operation on bit participation
// - Bit 2 selects control pin participation
// - Bit 0 chooses soft or immediate pin off
// - Unlisted config value flags invalid data
// - Clear faults clears status, releases alert
// - Clear never restarts; present faults re-set
// - Alert response drops alert, keeps status bits
// - Old faults retrigger only after clearing or at conversion turn-on
// - Key accepts any write length without NACK
// - Nonzero key locks only after reload
// - Checksum follows key data on read
// - Zero key unlocked; unwritten key reads zero
// - Locked: guard NACKs, store NACKs only if guard bit 0 set, invalid data
// - Locked read returns attempt status code
// - Mismatch counts; at three, NACK plus flag
// - Match below three replaces key, zeroes counter
// - Lock applied only at reload, never runtime
// - Operation on bit requests conversion
// - Pin off-action zero: soft stop ignored
`timescale 1ns/1ns
module pofp_ctl #(
    parameter int          NF       = 6,
    parameter logic [7:0]  DEV_ADDR = 8'h5a  // Arbitrary bus address
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                link_clk,
    input  wire logic                lk_req_valid,
    input  wire pofp_pkg::pofp_req_t lk_req,
    output logic                     lk_busy,
    output logic                     lk_rsp_valid,
    output pofp_pkg::pofp_rsp_t      lk_rsp,
    input  wire logic                strap_secondary,
    input  wire logic                control_input_pin,
    input  wire logic                vin_ok,
    input  wire logic [7:0]          nvm_cfg,
    input  wire logic [15:0]         nvm_key,
    input  wire logic [15:0]         nvm_checksum,
    input  wire logic [NF-1:0]       fault_src,
    input  wire logic                dnr_latched,
    output logic                     convert_en,
    output logic                     stop_soft,
    output logic                     store_req,
    output logic [15:0]              store_key,
    output logic [7:0]               extended_write_guard,
    output logic [NF+1:0]            comm_logic_status,
    output logic                     alert_out,
    output logic                     alert_oe
);
    localparam int SW = NF + 2;

    // ****************************************
    // Link side: request launch, answer capture
    // ****************************************
    pofp_pkg::pofp_lk_st_t lk_st_q;
    pofp_pkg::pofp_req_t   lk_req_q;
    pofp_pkg::pofp_rsp_t   lk_rsp_q;
    pofp_pkg::pofp_rsp_t   rsp_q;
    logic                  lk_tgl_q;
    logic                  lk_vld_q;
    logic                  rs_s1_q, rs_s2_q, rs_s3_q;
    logic                  rsp_tgl_q;

    // Answer toggle back into the link domain
    always_ff @(posedge link_clk or posedge rst)
        if (rst)
        begin
            rs_s1_q <= 1'b0;
            rs_s2_q <= 1'b0;
            rs_s3_q <= 1'b0;
        end
        else
        begin
            rs_s1_q <= rsp_tgl_q;
            rs_s2_q <= rs_s1_q;
            rs_s3_q <= rs_s2_q;
        end

    // Request held stable until the answer returns, so the word crossing is safe
    always_ff @(posedge link_clk or posedge rst)
        if (rst)
        begin
            lk_st_q  <= pofp_pkg::LK_IDLE;
            lk_req_q <= '0;
            lk_tgl_q <= 1'b0;
            lk_rsp_q <= '0;
            lk_vld_q <= 1'b0;
        end
        else
        begin
            lk_vld_q <= 1'b0;
            unique case (lk_st_q)
                pofp_pkg::LK_IDLE:
                    if (lk_req_valid)
                    begin
                        lk_req_q <= lk_req;
                        lk_tgl_q <= ~lk_tgl_q;
                        lk_st_q  <= pofp_pkg::LK_WAIT;
                    end
                pofp_pkg::LK_WAIT:
                    if (rs_s2_q ^ rs_s3_q)
                    begin
                        lk_rsp_q <= rsp_q;
                        lk_vld_q <= 1'b1;
                        lk_st_q  <= pofp_pkg::LK_IDLE;
                    end
            endcase
        end

    assign lk_busy      = (lk_st_q == pofp_pkg::LK_WAIT);
    assign lk_rsp_valid = lk_vld_q;
    assign lk_rsp       = lk_rsp_q;

    // ****************************************
    // Core side: synchronisers and boot load
    // ****************************************
    logic       rq_s1_q, rq_s2_q, rq_s3_q;
    logic [2:0] pin_s1_q, pin_s2_q;
    logic       fire;
    logic       load_q;

    // Request toggle into the core domain
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            rq_s1_q <= 1'b0;
            rq_s2_q <= 1'b0;
            rq_s3_q <= 1'b0;
        end
        else
        begin
            rq_s1_q <= lk_tgl_q;
            rq_s2_q <= rq_s1_q;
            rq_s3_q <= rq_s2_q;
        end

    assign fire = rq_s2_q ^ rq_s3_q;

    // Pins: strap, control pin, input good
    // Kept out of reset so the strap has settled by the load cycle
    for (genvar i = 0; i < 3; i++)
    begin : g_pin
        always_ff @(posedge clk)
        begin
            pin_s1_q[i] <= (i == 0) ? strap_secondary
                         : (i == 1) ? control_input_pin : vin_ok;
            pin_s2_q[i] <= pin_s1_q[i];
        end
    end

    // Load pulse one cycle after release; straps have settled by then
    always_ff @(posedge clk or posedge rst)
        if (rst)
            load_q <= 1'b1;
        else
            load_q <= 1'b0;

    // ****************************************
    // Command decode
    // ****************************************
    logic [7:0]    cfg_q, op_q, guard_q;
    logic [15:0]   key_q, key_latch_q;
    logic [1:0]    att_q;
    logic          locked_q, sec_q, alert_q;
    logic [SW-1:0] status_q;
    pofp_pkg::pofp_rsp_t rsp_d;
    logic          cfg_we, op_we, guard_we, key_we, att_inc, att_clr;
    logic          clr_all, restore, store, ara_ack, invalid_command_fault, ivd;
    logic [15:0]   key_new;
    logic [SW-1:0] w1c;
    logic          wr, rd;
    logic [7:0]    att_code, cfg_rd;

    assign wr = fire && (lk_req_q.kind == pofp_pkg::POFP_WR);
    assign rd = fire && (lk_req_q.kind == pofp_pkg::POFP_RD);
    // Reserved bits forced on read
    assign cfg_rd = {3'h0, cfg_q[4:2], 1'b1, cfg_q[0]};
    assign att_code = (att_q == 2'h0) ? pofp_pkg::ATT_0
                    : (att_q == 2'h1) ? pofp_pkg::ATT_1
                    : (att_q == 2'h2) ? pofp_pkg::ATT_2 : pofp_pkg::ATT_MAX;

    // One request handled per cycle, answer formed here
    always_comb
    begin
        rsp_d    = '0;
        cfg_we   = 1'b0;
        op_we    = 1'b0;
        guard_we = 1'b0;
        key_we   = 1'b0;
        key_new  = lk_req_q.data[15:0];
        att_inc  = 1'b0;
        att_clr  = 1'b0;
        clr_all  = 1'b0;
        restore  = 1'b0;
        store    = 1'b0;
        ara_ack  = 1'b0;
        invalid_command_fault      = 1'b0;
        ivd      = 1'b0;
        w1c      = '0;
        if (fire && lk_req_q.kind == pofp_pkg::POFP_ARA)
        begin
            // Only answers while alert is up
            rsp_d.nack = ~alert_q;
            rsp_d.len  = 3'h1;
            rsp_d.data = {24'h0, DEV_ADDR};
            ara_ack    = alert_q;
        end
        else if (wr || rd)
        begin
            rsp_d.len = 3'h1;
            case (lk_req_q.cmd)
                pofp_pkg::CMD_ENABLE_CFG:
                    if (sec_q)
                    begin
                        rsp_d.nack = 1'b1;
                        invalid_command_fault        = 1'b1;
                    end
                    else if (rd)
                        rsp_d.data = {24'h0, cfg_rd};
                    else if (lk_req_q.data[7:5] != 3'h0)
                    begin
                        rsp_d.nack = 1'b1;
                        ivd        = 1'b1;
                    end
                    else
                        cfg_we = 1'b1;
                pofp_pkg::CMD_OPERATION:
                    if (rd)
                        rsp_d.data = {24'h0, op_q[7] | sec_q, op_q[6:0]};
                    else
                        op_we = 1'b1;
                pofp_pkg::CMD_CLR_FAULTS:
                    clr_all = wr;
                pofp_pkg::CMD_LOCK_KEY:
                    if (rd)
                    begin
                        // Checksum trails the key or attempt code
                        rsp_d.len  = locked_q ? 3'h3 : 3'h4;
                        rsp_d.data = locked_q ? {8'h0, nvm_checksum, att_code}
                                              : {nvm_checksum, key_q};
                    end
                    else if (!locked_q)
                        key_we = 1'b1;
                    else if (att_q == pofp_pkg::ATT_LIM)
                    begin
                        rsp_d.nack = 1'b1;
                        ivd        = 1'b1;
                    end
                    else if (lk_req_q.data[15:0] == key_latch_q)
                    begin
                        key_we  = 1'b1;
                        key_new = lk_req_q.data[31:16];
                        att_clr = 1'b1;
                    end
                    else
                        att_inc = 1'b1;
                pofp_pkg::CMD_EXT_GUARD:
                    if (rd)
                        rsp_d.data = {24'h0, guard_q};
                    else if (locked_q)
                    begin
                        rsp_d.nack = 1'b1;
                        ivd        = 1'b1;
                    end
                    else
                        guard_we = 1'b1;
                pofp_pkg::CMD_STORE_ALL:
                    if (locked_q && guard_q[pofp_pkg::GUARD_NVM_STORE_LOCK_SELECT])
                    begin
                        rsp_d.nack = 1'b1;
                        ivd        = 1'b1;
                    end
                    else
                        store = wr;
                pofp_pkg::CMD_RESTORE:
                    restore = wr;
                pofp_pkg::CMD_STATUS:
                    if (rd)
                        rsp_d.data = 32'(status_q);
                    else
                        w1c = lk_req_q.data[SW-1:0];
                default:
                begin
                    rsp_d.nack = 1'b1;
                    invalid_command_fault        = 1'b1;
                end
            endcase
        end
    end

    // Answer word and toggle back to the link
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            rsp_q     <= '0;
            rsp_tgl_q <= 1'b0;
        end
        else if (fire)
        begin
            rsp_q     <= rsp_d;
            rsp_tgl_q <= ~rsp_tgl_q;
        end

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            cfg_q   <= '0;
            op_q    <= pofp_pkg::OP_RST;
            guard_q <= pofp_pkg::GUARD_RST;
            sec_q   <= 1'b0;
        end
        else
        begin
            if (load_q)
                sec_q <= pin_s2_q[0];
            if (load_q || restore)
                cfg_q <= nvm_cfg;
            else if (cfg_we)
                cfg_q <= lk_req_q.data[7:0];
            if (op_we)
                op_q <= lk_req_q.data[7:0];
            if (guard_we)
                guard_q <= lk_req_q.data[7:0];
        end

    // ****************************************
    // Lock key, latched key and attempts
    // ****************************************
    // Lock is decided only at reload, so runtime writes never relock
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            key_q       <= '0;
            key_latch_q <= '0;
            locked_q    <= 1'b0;
            att_q       <= '0;
        end
        else if (load_q || restore)
        begin
            key_q       <= nvm_key;
            key_latch_q <= nvm_key;
            locked_q    <= (nvm_key != 16'h0);
            att_q       <= '0;
        end
        else
        begin
            if (key_we)
                key_q <= key_new;
            if (att_clr)
                att_q <= '0;
            else if (att_inc)
                att_q <= att_q + 2'h1;
        end

    // Store pulse carries the operating key out to the NVM engine
    always_ff @(posedge clk or posedge rst)
        if (rst)
            store_req <= 1'b0;
        else
            store_req <= store;

    assign store_key            = key_q;
    assign extended_write_guard = guard_q;

    // ****************************************
    // Conversion gating
    // ****************************************
    logic pu_eff, pin_on, cmd_on, go, pin_off, conv_q, soft_q;

    assign pu_eff = cfg_q[pofp_pkg::CFG_PU] & ~sec_q;
    assign pin_on = ~cfg_q[pofp_pkg::CFG_CPR] | pin_s2_q[1];
    assign cmd_on = ~cfg_q[pofp_pkg::CFG_CMD] | op_q[pofp_pkg::OP_ON];
    // Both selected gates must agree; either one drops the output
    assign go = (~pu_eff | (pin_on & cmd_on)) & pin_s2_q[2] & ~dnr_latched;
    assign pin_off = cfg_q[pofp_pkg::CFG_CPR] & ~pin_s2_q[1];

    // Stop profile chosen on the falling edge of the request
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            conv_q <= 1'b0;
            soft_q <= 1'b0;
        end
        else
        begin
            conv_q <= go & ~load_q;
            if (conv_q && !go)
            begin
                if (!pu_eff || dnr_latched || !pin_s2_q[2])
                    soft_q <= 1'b0;
                else if (pin_off)
                    soft_q <= ~cfg_q[pofp_pkg::CFG_CPA];
                else
                    soft_q <= ~cfg_q[pofp_pkg::CFG_CPA]
                            | op_q[pofp_pkg::OP_SOFT];
            end
        end

    assign convert_en = conv_q;
    assign stop_soft  = soft_q;

    // ****************************************
    // Status and alert
    // ****************************************
    logic [SW-1:0] set_v, keep_v;
    logic          turn_on;

    assign turn_on = go & ~conv_q & ~load_q;
    assign set_v   = {fault_src, ivd, invalid_command_fault};
    // Faults still present re-set in the same cycle as a clear
    assign keep_v = (clr_all || turn_on) ? '0 : (status_q & ~w1c);

    always_ff @(posedge clk or posedge rst)
        if (rst)
            status_q <= '0;
        else
            status_q <= keep_v | set_v;

    // Only bits newly set raise the alert, so acknowledged ones stay quiet
    always_ff @(posedge clk or posedge rst)
        if (rst)
            alert_q <= 1'b0;
        else
            alert_q <= (alert_q & ~clr_all & ~ara_ack)
                     | (|(set_v & ~keep_v));

    assign comm_logic_status = status_q;
    assign alert_out         = 1'b0;
    assign alert_oe          = alert_q;

    // ****************************************
    // Assertions
    // ****************************************
    property p_sec_cfg;
        @(posedge clk) disable iff (rst)
        fire && sec_q && lk_req_q.kind != pofp_pkg::POFP_ARA
            && lk_req_q.cmd == pofp_pkg::CMD_ENABLE_CFG
        |=> rsp_q.nack && status_q[pofp_pkg::ST_IVC] && alert_q && $stable(cfg_q);
    endproperty
    a_sec_cfg: assert property (p_sec_cfg) else $error("secondary config access");

    property p_cfg_rd;
        @(posedge clk) disable iff (rst)
        rd && !sec_q && lk_req_q.cmd == pofp_pkg::CMD_ENABLE_CFG
        |=> rsp_q.data[7:5] == 3'h0 && rsp_q.data[1];
    endproperty
    a_cfg_rd: assert property (p_cfg_rd) else $error("config read bits wrong");

    property p_pu_zero;
        @(posedge clk) disable iff (rst)
        !load_q && !pu_eff && pin_s2_q[2] && !dnr_latched |=> conv_q;
    endproperty
    a_pu_zero: assert property (p_pu_zero) else $error("no conversion with gating off");

    property p_both;
        @(posedge clk) disable iff (rst)
        pu_eff && cfg_q[pofp_pkg::CFG_CMD] && cfg_q[pofp_pkg::CFG_CPR]
            && (!op_q[pofp_pkg::OP_ON] || !pin_s2_q[1]) |=> !conv_q;
    endproperty
    a_both: assert property (p_both) else $error("converting without both gates");

    property p_clear;
        @(posedge clk) disable iff (rst)
        clr_all && fault_src == '0 |=> status_q == '0 && !alert_q;
    endproperty
    a_clear: assert property (p_clear) else $error("clear faults left state");

    property p_ara;
        @(posedge clk) disable iff (rst)
        ara_ack && fault_src == '0 |=> !alert_q && status_q == $past(status_q);
    endproperty
    a_ara: assert property (p_ara) else $error("alert response wrong");

    property p_att_max;
        @(posedge clk) disable iff (rst)
        wr && locked_q && att_q == pofp_pkg::ATT_LIM && lk_req_q.cmd == pofp_pkg::CMD_LOCK_KEY
        |=> rsp_q.nack && status_q[pofp_pkg::ST_IVD] && att_q == pofp_pkg::ATT_LIM;
    endproperty
    a_att_max: assert property (p_att_max) else $error("key write not refused");

    property p_store_lock;
        @(posedge clk) disable iff (rst)
        wr && locked_q && guard_q[pofp_pkg::GUARD_NVM_STORE_LOCK_SELECT] && lk_req_q.cmd == pofp_pkg::CMD_STORE_ALL
        |=> rsp_q.nack && !store_req ##1 !store_req;
    endproperty
    a_store_lock: assert property (p_store_lock) else $error("locked store passed");

    property p_no_relock;
        @(posedge clk) disable iff (rst)
        !load_q && !restore |=> locked_q == $past(locked_q);
    endproperty
    a_no_relock: assert property (p_no_relock) else $error("lock changed at runtime");

    property p_att_read;
        @(posedge clk) disable iff (rst)
        rd && locked_q && att_q == 2'h1 && lk_req_q.cmd == pofp_pkg::CMD_LOCK_KEY
        |=> rsp_q.data[7:0] == pofp_pkg::ATT_1 && rsp_q.len == 3'h3;
    endproperty
    a_att_read: assert property (p_att_read) else $error("attempt code wrong");
endmodule // pofp_ctl

/* File: testbench/pofp_host.sv */
// Link-side host model that offers one request at a time
`timescale 1ns/1ns
module pofp_host (
    input  wire logic                link_clk,
    output logic                     lk_req_valid,
    output pofp_pkg::pofp_req_t      lk_req,
    input  wire logic                lk_busy,
    input  wire logic                lk_rsp_valid,
    input  wire pofp_pkg::pofp_rsp_t lk_rsp
);
    initial
    begin
        lk_req_valid = 1'b0;
        lk_req       = '0;
    end
    // Offer only while idle; scramble the lines once taken so stale data never helps
    task automatic xfer(input pofp_pkg::pofp_kind_t k, input logic [7:0] c,
                        input logic [31:0] d, output pofp_pkg::pofp_rsp_t r);
        int n;
        n = 0;
        @(negedge link_clk);
        while (lk_busy !== 1'b0)
            @(negedge link_clk);
        lk_req       <= '{k, c, 3'h4, d};
        lk_req_valid <= 1'b1;
        @(negedge link_clk);
        lk_req_valid <= 1'b0;
        lk_req       <= pofp_pkg::pofp_req_t'(~lk_req);
        while (lk_rsp_valid !== 1'b1 && n < 100)
        begin
            @(negedge link_clk);
            n++;
        end
        r = (n < 100) ? lk_rsp : 'x;  // A lost answer never matches
    endtask
endmodule // pofp_host

/* File: testbench/pofp_ctl_test.sv */
// Self-checking bench for the enable, fault and lock key command block
`timescale 1ns/1ns
module pofp_ctl_test;
    logic                clk, rst, link_clk, lk_req_valid, lk_busy, lk_rsp_valid;
    logic                strap_secondary, control_input_pin, vin_ok, dnr_latched;
    logic                convert_en, stop_soft, store_req, alert_out, alert_oe;
    logic [7:0]          nvm_cfg, extended_write_guard, comm_logic_status;
    logic [15:0]         nvm_key, store_key;
    logic [5:0]          fault_src;
    logic [19:0]         tb [10];  // Config, operation, pin, convert, soft check, soft
    pofp_pkg::pofp_req_t lk_req;
    pofp_pkg::pofp_rsp_t lk_rsp, r;
    int                  miscompares, n_compared, i;
    int                  n_store = 0;

    pofp_ctl DUT (.clk, .rst, .link_clk, .lk_req_valid, .lk_req, .lk_busy, .lk_rsp_valid,
        .lk_rsp, .strap_secondary, .control_input_pin, .vin_ok, .nvm_cfg, .nvm_key,
        .nvm_checksum(16'hc5a3), .fault_src, .dnr_latched, .convert_en, .stop_soft,
        .store_req, .store_key, .extended_write_guard, .comm_logic_status, .alert_out,
        .alert_oe);
    pofp_host host (.link_clk, .lk_req_valid, .lk_req, .lk_busy, .lk_rsp_valid, .lk_rsp);

    // ****************
    // Clocks and tasks
    // ****************
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Odd offset keeps the link clock out of phase with the core clock
    initial
    begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Settle time lets synchronised effects land before checking
    task automatic tx(input pofp_pkg::pofp_kind_t k, input logic [7:0] c, input logic [31:0] d);
        host.xfer(k, c, d, r);
        repeat (6) @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] c, input logic [31:0] d);
        tx(pofp_pkg::POFP_WR, c, d);
    endtask
    task automatic rd(input logic [7:0] c);
        tx(pofp_pkg::POFP_RD, c, 32'h0);
    endtask
    task automatic boot(input logic s);
        rst = 1'b1;
        strap_secondary = s;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    // Store pulses counted at the core clock; each one starts an NVM write
    always @(posedge clk)
        if (store_req === 1'b1)
            n_store++;
    task automatic end_sim();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #400000;
        miscompares++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        {rst, strap_secondary, control_input_pin, vin_ok, dnr_latched} = 5'h12;
        {nvm_cfg, nvm_key, fault_src} = {8'h1e, 16'h0, 6'h0};
        {miscompares, n_compared} = {32'h0, 32'h0};
        tb = '{20'h16000, 20'h1600c, 20'h1e008, 20'h1e80c, 20'h1e803, 20'h1f80c,
               20'h1f802, 20'h02004, 20'h1a804, 20'h1a003};
        boot(1'b0);
        rd(pofp_pkg::CMD_ENABLE_CFG);
        chk(r.data[7:0], 8'h1e);
        wr(pofp_pkg::CMD_ENABLE_CFG, 8'h14);
        rd(pofp_pkg::CMD_ENABLE_CFG);
        chk(r.data[7:0], 8'h16);
        wr(pofp_pkg::CMD_ENABLE_CFG, 8'h34);
        chk({r.nack, comm_logic_status[1]}, 2'h3);
        tx(pofp_pkg::POFP_ARA, 8'h0, 32'h0);
        chk({r.data[7:0], alert_oe, comm_logic_status[1]}, {8'h5a, 2'h1});
        fault_src = 6'h01;
        repeat (4) @(negedge clk);
        chk(alert_oe, 1'b1);
        wr(pofp_pkg::CMD_CLR_FAULTS, 32'h0);
        chk({comm_logic_status, alert_oe}, {8'h04, 1'b1});
        fault_src = 6'h00;
        wr(pofp_pkg::CMD_CLR_FAULTS, 32'h0);
        chk({comm_logic_status, alert_oe}, 9'h0);
        // Walk the gating combinations, pin changed last in each step
        for (i = 0; i < 10; i++)
        begin
            wr(pofp_pkg::CMD_ENABLE_CFG, tb[i][19:12]);
            wr(pofp_pkg::CMD_OPERATION, tb[i][11:4]);
            control_input_pin = tb[i][3];
            repeat (8) @(negedge clk);
            chk(convert_en, tb[i][2]);
            if (tb[i][1])
                chk(stop_soft, tb[i][0]);
        end
        rd(pofp_pkg::CMD_LOCK_KEY);
        chk({r.len, r.data}, {3'h4, 32'hc5a30000});
        wr(pofp_pkg::CMD_LOCK_KEY, 32'h1234);
        rd(pofp_pkg::CMD_LOCK_KEY);
        chk({r.len, r.data}, {3'h4, 32'hc5a31234});
        wr(pofp_pkg::CMD_EXT_GUARD, 32'h1);
        chk(extended_write_guard, 8'h01);
        wr(pofp_pkg::CMD_STORE_ALL, 32'h0);
        chk({r.nack, store_key}, {1'b0, 16'h1234});
        nvm_key = 16'h1234;
        wr(pofp_pkg::CMD_RESTORE, 32'h0);
        rd(pofp_pkg::CMD_LOCK_KEY);
        chk({r.len, r.data[23:0]}, {3'h3, 16'hc5a3, pofp_pkg::ATT_0});
        wr(pofp_pkg::CMD_STORE_ALL, 32'h0);
        chk(r.nack, 1'b1);
        wr(pofp_pkg::CMD_EXT_GUARD, 32'h1);
        chk({r.nack, comm_logic_status[1], extended_write_guard}, {2'h3, 8'h01});
        wr(pofp_pkg::CMD_LOCK_KEY, 32'h1);
        chk(r.nack, 1'b0);
        wr(pofp_pkg::CMD_LOCK_KEY, 32'h1234);
        rd(pofp_pkg::CMD_LOCK_KEY);
        chk({r.len, r.data[7:0]}, {3'h3, pofp_pkg::ATT_0});
        for (i = 0; i < 3; i++)
        begin
            wr(pofp_pkg::CMD_LOCK_KEY, 32'h1);
            rd(pofp_pkg::CMD_LOCK_KEY);
            chk(r.data[7:0], i == 2 ? pofp_pkg::ATT_MAX : pofp_pkg::ATT_1 + i);
        end
        wr(pofp_pkg::CMD_CLR_FAULTS, 32'h0);
        wr(pofp_pkg::CMD_LOCK_KEY, 32'h1234);
        chk({r.nack, comm_logic_status[1]}, 2'h3);
        // Secondary strap: config access refused, conversion follows input power
        boot(1'b1);
        rd(pofp_pkg::CMD_ENABLE_CFG);
        chk({r.nack, comm_logic_status[0], alert_oe, convert_en, alert_out}, 5'h1e);
        chk(n_store, 32'h1);
        end_sim();
    end
endmodule // pofp_ctl_test
